// ==== pkg/sbt_defines.vh ====
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH

// register offsets on the plain register port
`define SBT_OFS_CTRL_A      3'h0
`define SBT_OFS_CTRL_B      3'h1
`define SBT_OFS_CNT_LO      3'h2
`define SBT_OFS_CNT_HI      3'h3
`define SBT_OFS_CMPA_LO     3'h4
`define SBT_OFS_CMPA_HI     3'h5
`define SBT_OFS_CMPP        3'h6
`define SBT_OFS_STATUS      3'h7

// timer_control_a fields
`define SBT_A_PAUSE         7
`define SBT_A_CLK_HI        6
`define SBT_A_CLK_LO        4
`define SBT_A_ON            3

// timer_control_b fields
`define SBT_B_MODE_HI       7
`define SBT_B_MODE_LO       6
`define SBT_B_PIN_HI        5
`define SBT_B_PIN_LO        4
`define SBT_B_OLC           3
`define SBT_B_INV           2
`define SBT_B_SWAP          1
`define SBT_B_CLR           0

// status fields (write one to clear)
`define SBT_S_FLAG_A        0
`define SBT_S_FLAG_P        1

// reset values
`define SBT_RST_BYTE        8'h00
`define SBT_RST_WORD        16'h0000

// operating modes
`define SBT_MODE_CMP        2'h0
`define SBT_MODE_CAP        2'h1
`define SBT_MODE_PWM        2'h2
`define SBT_MODE_TMR        2'h3

// clock source codes
`define SBT_CK_SYS4         3'h0
`define SBT_CK_SYS          3'h1
`define SBT_CK_HI16         3'h2
`define SBT_CK_HI64         3'h3
`define SBT_CK_TBC          3'h4
`define SBT_CK_UNDEF        3'h5
`define SBT_CK_EXTR         3'h6
`define SBT_CK_EXTF         3'h7

// prescaler terminal counts
`define SBT_SYS4_LAST       2'h3
`define SBT_HI16_LAST       4'hF
`define SBT_HI64_LAST       6'h3F

`endif

// ==== verilog/sbt_edge_det.v ====
`timescale 1ns/1ps
// single-cycle rise and fall pulses of a synchronous level
module sbt_edge_det (
    input  wire ref_clk,
    input  wire rstn,
    input  wire sigIn,
    output wire risePulse,
    output wire fallPulse
);

    reg prev_r;

    // previous level; reset low so a high input at release reads as a rise
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sigIn;
        end
    end

    assign risePulse = sigIn & ~prev_r;
    assign fallPulse = ~sigIn & prev_r;

endmodule

// ==== verilog/sbt_timer.v ====
// Functional notes
// - comparator P matches counter upper byte
// - comparator A matches all 16 bits
// - counter not writable; on rise clears
// - overflow or selected match clears counter
// - pause bit holds count, resumes later
// - clock select picks counter clock source
// - code 101 gives no clock
// - on bit low stops, keeps count
// - on bit rising clears counter
// - on rising restores compare output level
// - control A low bits read zero
// - mode field selects operating mode
// - compare mode: none, low, high, toggle
// - pwm: inactive, active, pwm, single pulse
// - capture edge: rise, fall, both, off
// - equal level gives no visible change
// - external input and two output pins
// - counter read only, compare A read/write
// - output control: initial or active level
// - invert bit flips pin, not timer mode
// - swap bit exchanges period and duty
// - clear source: A match or P/overflow
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "sbt_defines.vh"
module sbt_timer (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire [2:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    input  wire       highClkTick,
    input  wire       timebaseTick,
    input  wire       extClockPin,
    input  wire       captureInPin,
    output wire       timerOutPin0,
    output wire       timerOutPin1,
    output wire       timerOutEn,
    output reg        matchAEvent,
    output reg        matchPEvent
);

    // ----------
    // registers and state
    // ----------
    reg        countPause_r;
    reg  [2:0] clockSourceSel_r;
    reg        moduleOn_r;
    reg  [1:0] operatingModeSel_r;
    reg  [1:0] pinFunctionSel_r;
    reg        outputLevelCtrl_r;
    reg        outputInvert_r;
    reg        periodDutySwap_r;
    reg        clearSourceSel_r;
    reg  [15:0] compareAValue_r;
    reg  [7:0] comparePValue_r;
    reg  [15:0] count_r;
    reg  [15:0] count_nxt;
    reg        onPrev_r;
    reg  [1:0] sysDiv_r;
    reg  [5:0] highDiv_r;
    reg        flagA_r;
    reg        flagP_r;
    reg        cmpLevel_r;
    reg        pulseDone_r;

    wire       extRise;
    wire       extFall;
    wire       capRise;
    wire       capFall;

    wire       onRise;
    wire       running;
    reg        clkSel;
    wire       tick;
    wire [15:0] countInc;
    wire       aHit;
    wire       pHit;
    wire [15:0] dutyValue;
    wire       dutyActive;
    reg        captureEdge;
    wire       captureHit;
    reg        counterClear;
    wire       wrStatus;

    // ----------
    // pin edge detectors
    // ----------
    // external clock source pin
    sbt_edge_det u_extEdge (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .sigIn     (extClockPin),
        .risePulse (extRise),
        .fallPulse (extFall)
    );

    // capture trigger pin
    sbt_edge_det u_capEdge (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .sigIn     (captureInPin),
        .risePulse (capRise),
        .fallPulse (capFall)
    );

    // ----------
    // clock source selection
    // ----------
    assign onRise  = moduleOn_r & ~onPrev_r;
    assign running = moduleOn_r & ~countPause_r & ~onRise;

    // prescalers stop with the module to save power
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sysDiv_r  <= 2'h0;
            highDiv_r <= 6'h00;
            onPrev_r  <= 1'b0;
        end else begin
            onPrev_r <= moduleOn_r;
            if (moduleOn_r) begin
                sysDiv_r <= sysDiv_r + 2'h1;
                if (highClkTick) begin
                    highDiv_r <= highDiv_r + 6'h01;
                end
            end
        end
    end

    // source mux, one tick per counter clock period
    always @* begin
        case (clockSourceSel_r)
            `SBT_CK_SYS4: clkSel = (sysDiv_r == `SBT_SYS4_LAST);
            `SBT_CK_SYS:  clkSel = 1'b1;
            `SBT_CK_HI16: clkSel = highClkTick &
                                   (highDiv_r[3:0] == `SBT_HI16_LAST);
            `SBT_CK_HI64: clkSel = highClkTick &
                                   (highDiv_r == `SBT_HI64_LAST);
            `SBT_CK_TBC:  clkSel = timebaseTick;
            `SBT_CK_EXTR: clkSel = extRise;
            `SBT_CK_EXTF: clkSel = extFall;
            default:      clkSel = 1'b0;
        endcase
    end

    // single pulse stops the counter once its pulse has ended
    assign tick = clkSel & running & ~pulseDone_r;

    // ----------
    // comparators
    // ----------
    assign countInc = count_r + 16'h0001;
    // A hits when the counter would reach its value; zero never hits
    assign aHit = tick & (countInc == compareAValue_r) &
                  (compareAValue_r != `SBT_RST_WORD);
    // P compares the upper byte; zero lands on the overflow
    assign pHit = tick & (countInc[15:8] == comparePValue_r) &
                  (countInc[7:0] == 8'h00);

    assign dutyValue  = periodDutySwap_r ? {comparePValue_r, 8'h00}
                                         : compareAValue_r;
    // duty at or above the period keeps the output active throughout
    assign dutyActive = (count_r < dutyValue);

    // capture trigger decode
    always @* begin
        case (pinFunctionSel_r)
            2'h0:    captureEdge = capRise;
            2'h1:    captureEdge = capFall;
            2'h2:    captureEdge = capRise | capFall;
            default: captureEdge = 1'b0;
        endcase
    end
    assign captureHit = moduleOn_r &
                        (operatingModeSel_r == `SBT_MODE_CAP) &
                        captureEdge;

    // clear event per mode
    always @* begin
        case (operatingModeSel_r)
            `SBT_MODE_PWM: counterClear = periodDutySwap_r ? aHit : pHit;
            `SBT_MODE_CAP: counterClear = pHit;
            default:       counterClear = clearSourceSel_r ? aHit
                                                           : pHit;
        endcase
    end

    // ----------
    // counter
    // ----------
    always @* begin
        count_nxt = count_r;
        if (onRise) begin
            count_nxt = `SBT_RST_WORD;
        end else if (tick) begin
            if (counterClear) begin
                count_nxt = `SBT_RST_WORD;
            end else begin
                count_nxt = countInc;
            end
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= `SBT_RST_WORD;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ----------
    // event pulses and sticky flags
    // ----------
    assign wrStatus = regWrite & (regAddr == `SBT_OFS_STATUS);

    // P event is suppressed when the clear source bit selects A outside pwm
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            matchAEvent <= 1'b0;
            matchPEvent <= 1'b0;
            flagA_r     <= 1'b0;
            flagP_r     <= 1'b0;
        end else begin
            matchAEvent <= aHit | captureHit;
            matchPEvent <= pHit & ~(clearSourceSel_r &
                           (operatingModeSel_r != `SBT_MODE_PWM));
            // a new event wins over a clear in the same cycle
            if (aHit | captureHit) begin
                flagA_r <= 1'b1;
            end else if (wrStatus & regWdata[`SBT_S_FLAG_A]) begin
                flagA_r <= 1'b0;
            end
            if (pHit & ~(clearSourceSel_r &
                (operatingModeSel_r != `SBT_MODE_PWM))) begin
                flagP_r <= 1'b1;
            end else if (wrStatus & regWdata[`SBT_S_FLAG_P]) begin
                flagP_r <= 1'b0;
            end
        end
    end

    // ----------
    // output waveform
    // ----------
    // compare level restarts from the output control bit at switch-on
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmpLevel_r  <= 1'b0;
            pulseDone_r <= 1'b0;
        end else begin
            if (onRise) begin
                cmpLevel_r <= outputLevelCtrl_r;
            end else if (aHit &
                         (operatingModeSel_r == `SBT_MODE_CMP)) begin
                case (pinFunctionSel_r)
                    2'h1:    cmpLevel_r <= 1'b0;
                    2'h2:    cmpLevel_r <= 1'b1;
                    2'h3:    cmpLevel_r <= ~cmpLevel_r;
                    default: cmpLevel_r <= cmpLevel_r;
                endcase
            end
            // single pulse ends at the duty point and is rearmed on
            if (onRise) begin
                pulseDone_r <= 1'b0;
            end else if (tick & (operatingModeSel_r == `SBT_MODE_PWM) &
                         (pinFunctionSel_r == 2'h3) &
                         (countInc >= dutyValue)) begin
                pulseDone_r <= 1'b1;
            end
        end
    end

    reg pinLevel;
    // active level follows output control; invert applies last
    always @* begin
        case (operatingModeSel_r)
            `SBT_MODE_CMP: pinLevel = cmpLevel_r;
            `SBT_MODE_PWM: begin
                case (pinFunctionSel_r)
                    2'h0:    pinLevel = ~outputLevelCtrl_r;
                    2'h1:    pinLevel = outputLevelCtrl_r;
                    2'h2:    pinLevel = dutyActive ? outputLevelCtrl_r
                                                   : ~outputLevelCtrl_r;
                    default: pinLevel = (moduleOn_r & ~pulseDone_r) ?
                                        outputLevelCtrl_r
                                      : ~outputLevelCtrl_r;
                endcase
            end
            default:       pinLevel = 1'b0;
        endcase
    end

    // pins idle undriven in timer and capture modes
    assign timerOutEn   = (operatingModeSel_r == `SBT_MODE_CMP) |
                          (operatingModeSel_r == `SBT_MODE_PWM);
    assign timerOutPin0 = timerOutEn & (pinLevel ^ outputInvert_r);
    assign timerOutPin1 = timerOutPin0;

    // ----------
    // register port
    // ----------
    // writes; capture overrides a same-cycle write to compare A
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            countPause_r       <= 1'b0;
            clockSourceSel_r   <= 3'h0;
            moduleOn_r         <= 1'b0;
            operatingModeSel_r <= 2'h0;
            pinFunctionSel_r   <= 2'h0;
            outputLevelCtrl_r  <= 1'b0;
            outputInvert_r     <= 1'b0;
            periodDutySwap_r   <= 1'b0;
            clearSourceSel_r   <= 1'b0;
            compareAValue_r    <= `SBT_RST_WORD;
            comparePValue_r    <= `SBT_RST_BYTE;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `SBT_OFS_CTRL_A: begin
                        countPause_r     <= regWdata[`SBT_A_PAUSE];
                        clockSourceSel_r <=
                            regWdata[`SBT_A_CLK_HI:`SBT_A_CLK_LO];
                        moduleOn_r       <= regWdata[`SBT_A_ON];
                    end
                    `SBT_OFS_CTRL_B: begin
                        operatingModeSel_r <=
                            regWdata[`SBT_B_MODE_HI:`SBT_B_MODE_LO];
                        pinFunctionSel_r   <=
                            regWdata[`SBT_B_PIN_HI:`SBT_B_PIN_LO];
                        outputLevelCtrl_r  <= regWdata[`SBT_B_OLC];
                        outputInvert_r     <= regWdata[`SBT_B_INV];
                        periodDutySwap_r   <= regWdata[`SBT_B_SWAP];
                        clearSourceSel_r   <= regWdata[`SBT_B_CLR];
                    end
                    `SBT_OFS_CMPA_LO: compareAValue_r[7:0]  <= regWdata;
                    `SBT_OFS_CMPA_HI: compareAValue_r[15:8] <= regWdata;
                    `SBT_OFS_CMPP:    comparePValue_r       <= regWdata;
                    default: ;
                endcase
            end
            if (captureHit) begin
                compareAValue_r <= count_r;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= `SBT_RST_BYTE;
        end else if (regRead) begin
            case (regAddr)
                `SBT_OFS_CTRL_A:  regRdata <= {countPause_r,
                                               clockSourceSel_r,
                                               moduleOn_r,
                                               3'h0};
                `SBT_OFS_CTRL_B:  regRdata <= {operatingModeSel_r,
                                               pinFunctionSel_r,
                                               outputLevelCtrl_r,
                                               outputInvert_r,
                                               periodDutySwap_r,
                                               clearSourceSel_r};
                `SBT_OFS_CNT_LO:  regRdata <= count_r[7:0];
                `SBT_OFS_CNT_HI:  regRdata <= count_r[15:8];
                `SBT_OFS_CMPA_LO: regRdata <= compareAValue_r[7:0];
                `SBT_OFS_CMPA_HI: regRdata <= compareAValue_r[15:8];
                `SBT_OFS_CMPP:    regRdata <= comparePValue_r;
                default:          regRdata <= {6'h00, flagP_r, flagA_r};
            endcase
        end else begin
            regRdata <= `SBT_RST_BYTE;
        end
    end

endmodule

// ==== sim/sbt_pin_model.sv ====
`timescale 1ns/1ps
// far-side pins: external count clock and capture trigger
module sbt_pin_model (
    input  wire ref_clk,
    input  wire rstn,
    input  wire extRun,
    input  wire capLevel,
    output reg  extClockPin,
    output reg  captureInPin
);
    reg phase_r;
    //------------------------------------------------------------
    // pin drivers
    //------------------------------------------------------------
    // clock stands still outside bursts; two cycles at each level
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r      <= 1'b0;
            extClockPin  <= 1'b0;
            captureInPin <= 1'b0;
        end else begin
            captureInPin <= capLevel;
            if (extRun) begin
                phase_r <= ~phase_r;
                if (phase_r)
                    extClockPin <= ~extClockPin;
            end
        end
    end
endmodule

// ==== sim/sbt_timer_properties.sv ====
`timescale 1ns/1ps
module sbt_timer_properties (
    input wire       ref_clk,
    input wire       rstn,
    input wire [2:0] regAddr,
    input wire [7:0] regWdata,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdata,
    input wire       timerOutPin0,
    input wire       timerOutPin1,
    input wire       timerOutEn,
    input wire       matchAEvent,
    input wire       matchPEvent
);
    reg  [7:0] ctlA_r;
    reg  [7:0] ctlB_r;
    reg  [7:0] cmpLo_r;
    reg  [7:0] cmpHi_r;
    reg  [7:0] cmpP_r;
    reg        capUsed_r;
    wire [1:0] mode  = ctlB_r[7:6];
    wire       stall = !ctlA_r[3] || ctlA_r[7] || ctlA_r[6:4] == 3'h5;
    //----------
    // shadow of software writes
    //----------
    // capture may rewrite compare A, so its check stops once used
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctlA_r    <= 8'h00;
            ctlB_r    <= 8'h00;
            cmpLo_r   <= 8'h00;
            cmpHi_r   <= 8'h00;
            cmpP_r    <= 8'h00;
            capUsed_r <= 1'b0;
        end else begin
            if (regWrite && regAddr == 3'h0) ctlA_r <= regWdata;
            if (regWrite && regAddr == 3'h1) ctlB_r <= regWdata;
            if (regWrite && regAddr == 3'h4) cmpLo_r <= regWdata;
            if (regWrite && regAddr == 3'h5) cmpHi_r <= regWdata;
            if (regWrite && regAddr == 3'h6) cmpP_r <= regWdata;
            if (mode == 2'h1) capUsed_r <= 1'b1;
        end
    end
    //----------
    // properties
    //----------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence quiet3;
        (stall && mode != 2'h1) [*3];
    endsequence
    sequence noPClear3;
        (ctlB_r[0] && mode != 2'h2) [*3];
    endsequence
    a_pin_copy: assert property (timerOutPin1 == timerOutPin0)
        else $error("output pin copies differ");
    a_en_mode: assert property (
        timerOutEn == (mode == 2'h0 || mode == 2'h2))
        else $error("output enable does not follow mode");
    a_pin_idle: assert property (!timerOutEn |-> !timerOutPin0)
        else $error("pin driven while output unused");
    a_ctla_read: assert property (
        regRead && regAddr == 3'h0 |=> regRdata == {ctlA_r[7:3], 3'h0})
        else $error("control A read wrong");
    a_ctlb_read: assert property (
        regRead && regAddr == 3'h1 |=> regRdata == ctlB_r)
        else $error("control B read wrong");
    a_cmpa_read: assert property (
        regRead && regAddr[2:1] == 2'h2 && !capUsed_r
        |=> regRdata == (regAddr[0] ? cmpHi_r : cmpLo_r))
        else $error("compare A read wrong");
    a_cmpp_read: assert property (
        regRead && regAddr == 3'h6 |=> regRdata == cmpP_r)
        else $error("compare P read wrong");
    a_rd_quiet: assert property (!regRead |=> regRdata == 8'h00)
        else $error("read data outside read cycle");
    a_stall_quiet: assert property (
        quiet3 |-> !matchAEvent && !matchPEvent)
        else $error("event while counter held");
    a_p_suppress: assert property (noPClear3 |-> !matchPEvent)
        else $error("comparator P event while A clears");
    a_pwm_force: assert property (
        (mode == 2'h2 && !ctlB_r[5] && ctlA_r[3]) [*2]
        |-> timerOutPin0 == ((ctlB_r[4] ~^ ctlB_r[3]) ^ ctlB_r[2]))
        else $error("forced pwm level wrong");
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    reg        ref_clk;
    reg        rstn;
    reg  [2:0] regAddr;
    reg  [7:0] regWdata;
    reg        regWrite;
    reg        regRead;
    wire [7:0] regRdata;
    reg        highClkTick;
    reg        timebaseTick;
    reg        extRun;
    reg        capLevel;
    wire       extClockPin;
    wire       captureInPin;
    wire       timerOutPin0;
    wire       timerOutPin1;
    wire       timerOutEn;
    wire       matchAEvent;
    wire       matchPEvent;
    integer    seed;
    integer    fails;
    integer    comparisons;
    integer    tickCnt;
    integer    i;
    integer    n;
    integer    cv;
    reg  [7:0] rv;

    sbt_timer u_sbt_timer (.*);
    sbt_pin_model u_sbt_pin_model (.*);

    //----------
    // clock, tick sources, watchdog
    //----------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // high clock tick every 3 cycles, time base every 5
    always @(posedge ref_clk) begin
        tickCnt      <= (tickCnt == 14) ? 0 : tickCnt + 1;
        highClkTick  <= (tickCnt % 3) == 0;
        timebaseTick <= (tickCnt % 5) == 0;
    end
    // run needs some 12500 cycles; cut off well beyond
    initial begin
        #200000;
        fails = fails + 1;
        end_of_test;
    end

    //----------
    // bus tasks, compares, expectations
    //----------
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            regAddr  <= a;
            regWdata <= d;
            regWrite <= 1'b1;
            @(posedge ref_clk);
            regWrite <= 1'b0;
        end
    endtask
    task report(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rdChk(input [2:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge ref_clk);
            regRead <= 1'b0;
            #1;
            report({8'h00, regRdata}, {8'h00, exp});
        end
    endtask
    task chkPin(input exp);
        report({15'h0, timerOutPin0}, {15'h0, exp});
    endtask
    task chkN(input integer got, input integer exp);
        report(got[15:0], exp[15:0]);
    endtask
    // cycles up to the next event; 2000 means none came
    task waitEvt(input p, output integer k);
        begin
            k = 0;
            do begin
                @(posedge ref_clk);
                #1;
                k = k + 1;
            end while ((p ? matchPEvent : matchAEvent) !== 1'b1 && k < 2000);
        end
    endtask
    task countHi(input integer len, output integer k);
        begin
            k = 0;
            repeat (len) begin
                @(posedge ref_clk);
                #1;
                k = k + (timerOutPin0 === 1'b1);
            end
        end
    endtask
    function expPin(input [1:0] pf, input olc);
        expPin = (pf == 2'h0) ? olc : (pf == 2'h3) ? !olc : pf[1];
    endfunction
    // gap of a count of four, per clock source code
    function integer expGap(input [2:0] s);
        case (s)
            3'h0: expGap = 16;
            3'h1: expGap = 4;
            3'h2: expGap = 192;
            3'h3: expGap = 768;
            3'h4: expGap = 20;
            3'h5: expGap = 2000;
            default: expGap = 16;
        endcase
    endfunction
    task end_of_test;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    //----------
    // tests
    //----------
    initial begin
        seed = 32'h5cdc96fd;
        fails = 0;
        comparisons = 0;
        tickCnt = 0;
        rstn = 1'b0;
        regAddr = 3'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        highClkTick = 1'b0;
        timebaseTick = 1'b0;
        extRun = 1'b0;
        capLevel = 1'b0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        for (i = 0; i < 7; i = i + 1)
            rdChk(i[2:0], 8'h00);
        chkPin(1'b0);
        $display("test reset values done");
        // random fields; capture mode kept out until the end
        n = $random(seed);
        rv = n[7:0] & 8'hBF;
        wr(3'h1, rv);
        wr(3'h4, n[15:8]);
        wr(3'h5, n[23:16]);
        wr(3'h6, n[31:24]);
        wr(3'h0, n[7:0] & 8'hF7);
        wr(3'h2, 8'hA5);
        wr(3'h3, 8'h5A);
        rdChk(3'h1, rv);
        rdChk(3'h4, n[15:8]);
        rdChk(3'h5, n[23:16]);
        rdChk(3'h6, n[31:24]);
        rdChk(3'h0, n[7:0] & 8'hF0);
        rdChk(3'h2, 8'h00);
        rdChk(3'h3, 8'h00);
        $display("test register access done");
        // compare mode: every pin function, level and inversion
        cv = 3 + n[3:0];
        wr(3'h4, cv[7:0]);
        wr(3'h5, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(3'h0, 8'h10);
            wr(3'h1, {2'b00, i[3:2], i[1], i[0], 2'b01});
            wr(3'h0, 8'h18);
            repeat (2) @(posedge ref_clk);
            #1;
            chkPin(i[1] ^ i[0]);
            waitEvt(1'b0, n);
            chkPin(expPin(i[3:2], i[1]) ^ i[0]);
            waitEvt(1'b0, n);
            chkN(n, cv);
        end
        // pause, no-clock code and off must all hold the count
        wr(3'h0, 8'h98);
        repeat (30) @(posedge ref_clk);
        wr(3'h0, 8'h18);
        waitEvt(1'b0, n);
        waitEvt(1'b0, n);
        chkN(n, cv);
        wr(3'h0, 8'h10);
        repeat (20) @(posedge ref_clk);
        wr(3'h0, 8'h58);
        repeat (3) @(posedge ref_clk);
        rdChk(3'h2, 8'h00);
        rdChk(3'h3, 8'h00);
        $display("test compare output done");
        // timer mode, count of four, every clock source
        wr(3'h4, 8'h04);
        wr(3'h1, 8'hC1);
        @(posedge ref_clk);
        extRun <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            wr(3'h0, 8'h00);
            wr(3'h0, {1'b0, i[2:0], 4'h8});
            waitEvt(1'b0, n);
            waitEvt(1'b0, n);
            chkN(n, expGap(i[2:0]));
        end
        extRun <= 1'b0;
        // comparator P on the upper byte only
        wr(3'h0, 8'h00);
        wr(3'h6, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h18);
        waitEvt(1'b1, n);
        waitEvt(1'b1, n);
        chkN(n, 256);
        rdChk(3'h7, 8'h03);
        $display("test clock sources done");
        // pwm: period 256 from P, duty 64 from A
        wr(3'h4, 8'h40);
        for (i = 0; i < 4; i = i + 1) begin
            wr(3'h0, 8'h00);
            wr(3'h1, {2'b10, i[1:0], 4'h8});
            wr(3'h0, 8'h18);
            repeat (300) @(posedge ref_clk);
            countHi(512, n);
            chkN(n, (i == 1) ? 512 : (i == 2) ? 128 : 0);
        end
        // swapped roles: period 576 from A, duty 256 from P
        wr(3'h0, 8'h00);
        wr(3'h5, 8'h02);
        wr(3'h1, 8'hAA);
        wr(3'h0, 8'h18);
        repeat (600) @(posedge ref_clk);
        countHi(1152, n);
        chkN(n, 512);
        $display("test pwm done");
        // capture: one rise and one fall per trigger choice
        for (i = 0; i < 4; i = i + 1) begin
            wr(3'h0, 8'h00);
            wr(3'h1, {2'b01, i[1:0], 4'h0});
            wr(3'h5, 8'hFF);
            wr(3'h0, 8'h18);
            n = 0;
            repeat (2) begin
                @(posedge ref_clk);
                capLevel <= ~capLevel;
                repeat (10) begin
                    @(posedge ref_clk);
                    #1;
                    n = n + (matchAEvent === 1'b1);
                end
            end
            chkN(n, (i == 2) ? 2 : (i == 3) ? 0 : 1);
        end
        $display("test capture done");
        end_of_test;
    end
endmodule

bind sbt_timer sbt_timer_properties u_sbt_timer_properties (.*);
